// *** src/adcseq_approx.v ***
// successive approximation accumulator
`timescale 1ns/1ps
`include "adcseq_defines.vh"

module adcseq_approx (
	input wire clk,
	input wire srst,
	input wire load,
	input wire step,
	input wire cmp_above,
	input wire ten_bit_res_sel,
	output reg [9:0] approx_accum_reg
);

	reg [9:0] mask;
	wire [9:0] next_mask;
	wire [9:0] valid;

	assign next_mask = mask >> 1;
	assign valid = ten_bit_res_sel ? `ADCSEQ_MASK_TEN : `ADCSEQ_MASK_EIGHT;

	// ----------------------------------------
	// msb first trial and decide
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			approx_accum_reg <= 10'h000;
			mask <= 10'h000;
		end else if (load) begin
			approx_accum_reg <= `ADCSEQ_APPROX_MSB; // [R16]
			mask <= `ADCSEQ_APPROX_MSB;
		end else if (step) begin
			// clear the trial bit when input is below, then try the next bit
			approx_accum_reg <= ((cmp_above ? approx_accum_reg : (approx_accum_reg & ~mask))
				| (next_mask & valid)); // [R15] [R16]
			mask <= next_mask;
		end
	end

endmodule

// *** src/adcseq_defines.vh ***
// shared constants for the adc channel sequencer
`ifndef ADCSEQ_DEFINES_VH
`define ADCSEQ_DEFINES_VH

// ----------------------------------------
// register byte offsets and read view selects
// ----------------------------------------
`define ADCSEQ_OFS_CTRL0 8'h00
`define ADCSEQ_OFS_CTRL1 8'h04
`define ADCSEQ_OFS_STATUS 8'h08
`define ADCSEQ_VIEW_URJ 3'h2
`define ADCSEQ_VIEW_SLJ 3'h3
`define ADCSEQ_VIEW_ULJ 3'h4

// ----------------------------------------
// field positions
// ----------------------------------------
`define ADCSEQ_C0_STS_LO 0
`define ADCSEQ_C0_STS_HI 1
`define ADCSEQ_C0_TEN 2
`define ADCSEQ_C1_CODE_LO 0
`define ADCSEQ_C1_CODE_HI 3
`define ADCSEQ_C1_EIGHT 4
`define ADCSEQ_C1_MULTI 5
`define ADCSEQ_C1_CONT 6
`define ADCSEQ_ST_SEQ_DONE 8
`define ADCSEQ_ST_BUSY 9

// ----------------------------------------
// reset values
// ----------------------------------------
`define ADCSEQ_CTRL0_RST 3'h0
`define ADCSEQ_CTRL1_RST 7'h00

// ----------------------------------------
// conversion phases and their lengths in adc clocks
// ----------------------------------------
`define ADCSEQ_PH_IDLE 3'h0
`define ADCSEQ_PH_INIT 3'h1
`define ADCSEQ_PH_XFER 3'h2
`define ADCSEQ_PH_FINAL 3'h3
`define ADCSEQ_PH_RESOL 3'h4
`define ADCSEQ_LEN_INIT 5'h02
`define ADCSEQ_LEN_XFER 5'h02
`define ADCSEQ_LEN_FINAL_MIN 5'h02
`define ADCSEQ_LEN_RES8 5'h0a
`define ADCSEQ_LEN_TEN_BIT_RES_SEL 5'h0c
`define ADCSEQ_BITS8 5'h08
`define ADCSEQ_BITS10 5'h0a

// ----------------------------------------
// approximation register constants
// ----------------------------------------
`define ADCSEQ_APPROX_MSB 10'h200
`define ADCSEQ_MASK_TEN 10'h3ff
`define ADCSEQ_MASK_EIGHT 10'h3fc

`endif

// *** src/adcseq_phase_timer.v ***
// conversion phase timer stepping on adc clock ticks
`timescale 1ns/1ps
`include "adcseq_defines.vh"

module adcseq_phase_timer #(
	parameter CW = 5
) (
	input wire clk,
	input wire srst,
	input wire tick,
	input wire abort,
	input wire run,
	input wire [1:0] final_sample_time_sel,
	input wire ten_bit_res_sel,
	output reg [2:0] phase,
	output reg [CW-1:0] cnt,
	output reg done
);

	reg [CW-1:0] len;

	// ----------------------------------------
	// phase length
	// ----------------------------------------
	always @* begin
		case (phase)
			`ADCSEQ_PH_INIT: len = `ADCSEQ_LEN_INIT; // [R9]
			`ADCSEQ_PH_XFER: len = `ADCSEQ_LEN_XFER; // [R9]
			`ADCSEQ_PH_FINAL: len = `ADCSEQ_LEN_FINAL_MIN << final_sample_time_sel; // [R10] [R19]
			`ADCSEQ_PH_RESOL: len = ten_bit_res_sel ? `ADCSEQ_LEN_TEN_BIT_RES_SEL : `ADCSEQ_LEN_RES8; // [R11]
			default: len = `ADCSEQ_LEN_INIT;
		endcase
	end

	// ----------------------------------------
	// phase sequencing
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst || abort) begin
			phase <= `ADCSEQ_PH_IDLE; // [R21]
			cnt <= {CW{1'b0}};
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (tick) begin
				if (phase == `ADCSEQ_PH_IDLE) begin
					cnt <= {CW{1'b0}};
					if (run)
						phase <= `ADCSEQ_PH_INIT;
				end else if (cnt == len - 1'b1) begin
					cnt <= {CW{1'b0}};
					case (phase) // [R8]
						`ADCSEQ_PH_INIT: phase <= `ADCSEQ_PH_XFER;
						`ADCSEQ_PH_XFER: phase <= `ADCSEQ_PH_FINAL;
						`ADCSEQ_PH_FINAL: phase <= `ADCSEQ_PH_RESOL;
						`ADCSEQ_PH_RESOL: begin
							phase <= `ADCSEQ_PH_IDLE;
							done <= 1'b1;
						end
						default: phase <= `ADCSEQ_PH_IDLE;
					endcase
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
		end
	end

endmodule

// *** src/adcseq_top.v ***
// adc channel sequencer with conversion timing and avalon register slave
// Functional notes
// R1: single-channel code 0-7 external inputs, 8-11 reserved, 12-15 references and test.
// R2: single-channel runs fill results 0-3 or 0-7 from one input.
// R3: multi four-conversion: low code bits ignored, upper bits pick group of four.
// R4: multi eight-conversion: top code bit picks inputs 0-7 or 8-15.
// R5: group channels convert ascending, results fill ascending.
// R6: continuous select repeats passes; clear means one pass.
// R7: results readable as unsigned right, signed left and unsigned left views.
// R8: each conversion runs initial sample, transfer, final sample, resolution.
// R9: initial sample and transfer last two adc clocks each.
// R10: final sample lasts 2, 4, 8 or 16 adc clocks by field.
// R11: resolution takes ten clocks for 8-bit, twelve for 10-bit.
// R12: initial sample routes mux input through sample capacitor to amplifier.
// R13: transfer disconnects capacitor from mux; amplifier drives dac array.
// R14: final sample bypasses capacitor and amplifier; mux drives dac array.
// R15: resolution converts dac voltage and accumulates the code.
// R16: approximation resolves msb first, trial set then kept or cleared.
// R17: on completion the approximation value goes to its result register.
// R18: per-result done flag sets when that result register is written.
// R19: final sample field 00,01,10,11 gives 2,4,8,16 clocks.
// R20: reserved and test codes still get full conversion timing.
// R21: after reset idle with all analog switches open.
`timescale 1ns/1ps
`include "adcseq_defines.vh"

module adcseq_top #(
	parameter ADC_DIV = 12,
	parameter NRES = 8
) (
	input wire clk,
	input wire srst,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire cmp_in,
	output reg [3:0] mux_sel,
	output reg sw_in_to_cap,
	output reg sw_amp_to_dac,
	output reg sw_mux_to_dac,
	output wire [9:0] dac_code
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	reg [2:0] adc_ctrl_reg0;
	reg [6:0] adc_ctrl_reg1;
	reg [NRES-1:0] per_result_done_flag;
	reg seq_complete;
	reg seq_active;
	reg [2:0] conv_idx;
	reg [9:0] result_reg [0:NRES-1];
	reg [NRES-1:0] result_ten;
	reg [7:0] div_cnt;
	reg tick;
	reg cmp_s1;
	reg cmp_s2;
	reg ack;
	reg [3:0] next_chan;
	reg [31:0] next_rdata;
	reg [9:0] view_val;
	reg view_ten;
	wire [1:0] final_sample_time_sel;
	wire ten_bit_res_sel;
	wire [3:0] chan_code;
	wire eight_conv_sel;
	wire multi_channel_sel;
	wire cont_sel;
	wire bus_req;
	wire wr_go;
	wire ctrl1_wr;
	wire [2:0] phase;
	wire [4:0] ph_cnt;
	wire conv_done;
	wire [4:0] res_bits;
	wire sar_load;
	wire sar_step;
	wire [9:0] approx_accum_reg;
	wire [2:0] last_idx;
	wire [7:0] rd_view_word;
	wire [2:0] rd_idx;
	integer i;

	assign final_sample_time_sel = adc_ctrl_reg0[`ADCSEQ_C0_STS_HI:`ADCSEQ_C0_STS_LO];
	assign ten_bit_res_sel = adc_ctrl_reg0[`ADCSEQ_C0_TEN];
	assign chan_code = adc_ctrl_reg1[`ADCSEQ_C1_CODE_HI:`ADCSEQ_C1_CODE_LO];
	assign eight_conv_sel = adc_ctrl_reg1[`ADCSEQ_C1_EIGHT];
	assign multi_channel_sel = adc_ctrl_reg1[`ADCSEQ_C1_MULTI];
	assign cont_sel = adc_ctrl_reg1[`ADCSEQ_C1_CONT];
	assign dac_code = approx_accum_reg;

	// ----------------------------------------
	// avalon handshake
	// ----------------------------------------
	// one wait state: read data is captured on the first edge, the
	// access completes on the second one
	assign bus_req = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~ack;
	assign wr_go = avs_write & ack;
	assign ctrl1_wr = wr_go && avs_byteenable[0] && ({avs_address[7:2], 2'b00} == `ADCSEQ_OFS_CTRL1);

	always @(posedge clk) begin
		if (srst)
			ack <= 1'b0;
		else
			ack <= bus_req & ~ack;
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			adc_ctrl_reg0 <= `ADCSEQ_CTRL0_RST;
			adc_ctrl_reg1 <= `ADCSEQ_CTRL1_RST;
		end else if (wr_go && avs_byteenable[0]) begin
			if ({avs_address[7:2], 2'b00} == `ADCSEQ_OFS_CTRL0)
				adc_ctrl_reg0 <= avs_writedata[2:0];
			if ({avs_address[7:2], 2'b00} == `ADCSEQ_OFS_CTRL1)
				adc_ctrl_reg1 <= avs_writedata[6:0];
		end
	end

	// ----------------------------------------
	// adc clock tick and comparator sync
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			div_cnt <= 8'h00;
			tick <= 1'b0;
		end else if (div_cnt == ADC_DIV[7:0] - 8'h01) begin
			div_cnt <= 8'h00;
			tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 8'h01;
			tick <= 1'b0;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			cmp_s1 <= 1'b0;
			cmp_s2 <= 1'b0;
		end else begin
			cmp_s1 <= cmp_in;
			cmp_s2 <= cmp_s1;
		end
	end

	// ----------------------------------------
	// phase timer and approximation
	// ----------------------------------------
	adcseq_phase_timer #(
		.CW(5)
	) u_timer (
		.clk(clk),
		.srst(srst),
		.tick(tick),
		.abort(ctrl1_wr),
		.run(seq_active),
		.final_sample_time_sel(final_sample_time_sel),
		.ten_bit_res_sel(ten_bit_res_sel),
		.phase(phase),
		.cnt(ph_cnt),
		.done(conv_done)
	);

	// first resolution clock loads the msb trial, then one bit per clock,
	// the last clock only hands the value over
	assign res_bits = ten_bit_res_sel ? `ADCSEQ_BITS10 : `ADCSEQ_BITS8;
	assign sar_load = tick && (phase == `ADCSEQ_PH_RESOL) && (ph_cnt == 5'h00); // [R15]
	assign sar_step = tick && (phase == `ADCSEQ_PH_RESOL) && (ph_cnt != 5'h00) && (ph_cnt <= res_bits); // [R16]

	adcseq_approx u_approx (
		.clk(clk),
		.srst(srst),
		.load(sar_load),
		.step(sar_step),
		.cmp_above(cmp_s2),
		.ten_bit_res_sel(ten_bit_res_sel),
		.approx_accum_reg(approx_accum_reg)
	);

	// ----------------------------------------
	// channel decode
	// ----------------------------------------
	always @* begin
		if (!multi_channel_sel)
			next_chan = chan_code; // [R1] [R2] [R20]
		else if (!eight_conv_sel)
			next_chan = {chan_code[3:2], conv_idx[1:0]}; // [R3] [R5]
		else
			next_chan = {chan_code[3], conv_idx}; // [R4] [R5]
	end

	assign last_idx = eight_conv_sel ? 3'h7 : 3'h3;

	// ----------------------------------------
	// analog switch controls
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			mux_sel <= 4'h0;
			sw_in_to_cap <= 1'b0; // [R21]
			sw_amp_to_dac <= 1'b0;
			sw_mux_to_dac <= 1'b0;
		end else begin
			mux_sel <= next_chan;
			sw_in_to_cap <= (phase == `ADCSEQ_PH_INIT); // [R12]
			sw_amp_to_dac <= (phase == `ADCSEQ_PH_XFER); // [R13]
			sw_mux_to_dac <= (phase == `ADCSEQ_PH_FINAL); // [R14]
		end
	end

	// ----------------------------------------
	// sequence control and result storage
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			seq_active <= 1'b0; // [R21]
			conv_idx <= 3'h0;
			seq_complete <= 1'b0;
			per_result_done_flag <= {NRES{1'b0}};
		end else begin
			if (ctrl1_wr) begin
				// restart from the first result; old flags go away
				seq_active <= 1'b1;
				conv_idx <= 3'h0;
				seq_complete <= 1'b0;
				per_result_done_flag <= {NRES{1'b0}};
			end
			if (conv_done) begin
				// a completion landing with a restart still sets its flag
				per_result_done_flag[conv_idx] <= 1'b1; // [R18]
				if (!ctrl1_wr) begin
					if (conv_idx == last_idx) begin
						seq_complete <= 1'b1;
						conv_idx <= 3'h0; // [R2] [R6]
						if (!cont_sel)
							seq_active <= 1'b0; // [R6]
					end else begin
						conv_idx <= conv_idx + 3'h1; // [R5]
					end
				end
			end
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			result_ten <= {NRES{1'b0}};
			for (i = 0; i < NRES; i = i + 1)
				result_reg[i] <= 10'h000;
		end else if (conv_done) begin
			result_reg[conv_idx] <= approx_accum_reg; // [R17]
			result_ten[conv_idx] <= ten_bit_res_sel;
		end
	end

	// ----------------------------------------
	// read views
	// ----------------------------------------
	// results are kept left aligned in ten bits, so 8-bit values carry
	// two zero bits at the bottom that the right view shifts away
	assign rd_view_word = {avs_address[7:2], 2'b00};
	assign rd_idx = avs_address[4:2];

	always @* begin
		view_val = result_reg[rd_idx];
		view_ten = result_ten[rd_idx];
		next_rdata = 32'h00000000;
		case (avs_address[7:5])
			`ADCSEQ_VIEW_URJ: begin
				if (view_ten)
					next_rdata = {22'h000000, view_val}; // [R7]
				else
					next_rdata = {24'h000000, view_val[9:2]};
			end
			`ADCSEQ_VIEW_SLJ: next_rdata = {16'h0000, ~view_val[9], view_val[8:0], 6'h00}; // [R7]
			`ADCSEQ_VIEW_ULJ: next_rdata = {16'h0000, view_val, 6'h00}; // [R7]
			default: begin
				if (rd_view_word == `ADCSEQ_OFS_CTRL0)
					next_rdata = {29'h00000000, adc_ctrl_reg0};
				else if (rd_view_word == `ADCSEQ_OFS_CTRL1)
					next_rdata = {25'h0000000, adc_ctrl_reg1};
				else if (rd_view_word == `ADCSEQ_OFS_STATUS) begin
					next_rdata[NRES-1:0] = per_result_done_flag;
					next_rdata[`ADCSEQ_ST_SEQ_DONE] = seq_complete;
					next_rdata[`ADCSEQ_ST_BUSY] = seq_active;
				end
			end
		endcase
	end

	always @(posedge clk) begin
		if (srst)
			avs_readdata <= 32'h00000000;
		else if (avs_read && !ack)
			avs_readdata <= next_rdata;
	end

endmodule

// *** test/adcseq_analog.sv ***
// behavioural analog front end: input levels and comparator
`timescale 1ns/1ps
module adcseq_analog (
	input wire [159:0] levels,
	input wire [3:0] mux_sel,
	input wire [9:0] dac_code,
	output wire cmp_in
);
	// levels stand for mid-code voltages, so a tie reads as above
	assign cmp_in = levels[mux_sel*10 +: 10] >= dac_code;
endmodule

// *** test/adcseq_top_chk.sv ***
// port assertions for the adc sequencer
`timescale 1ns/1ps
module adcseq_chk #(
	parameter ADC_DIV = 12
) (
	input wire clk,
	input wire srst,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire [3:0] mux_sel,
	input wire sw_in_to_cap,
	input wire sw_amp_to_dac,
	input wire sw_mux_to_dac,
	input wire [9:0] dac_code
);
	// ----
	// phase run lengths
	// ----
	int n_in = 0;
	int n_xf = 0;
	wire rd_done = avs_read && !avs_waitrequest;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	always @(posedge clk) begin
		n_in <= sw_in_to_cap ? n_in + 1 : 0;
		n_xf <= sw_amp_to_dac ? n_xf + 1 : 0;
	end
	// ----
	// properties
	// ----
	a_reset_idle: assert property (disable iff (1'b0) srst |=>
		!sw_in_to_cap && !sw_amp_to_dac && !sw_mux_to_dac && mux_sel == 4'h0 && dac_code == 10'h000)
		else $error("outputs not idle after reset");
	a_switch_exclusive: assert property ($onehot0({sw_in_to_cap, sw_amp_to_dac, sw_mux_to_dac}))
		else $error("two switch phases at once");
	a_init_len: assert property ($rose(sw_amp_to_dac) |-> n_in == 2 * ADC_DIV)
		else $error("initial sample length wrong");
	a_xfer_len: assert property ($rose(sw_mux_to_dac) |-> n_xf == 2 * ADC_DIV)
		else $error("transfer length wrong");
	a_xfer_order: assert property ($rose(sw_amp_to_dac) |-> $past(sw_in_to_cap))
		else $error("transfer not after initial sample");
	a_final_order: assert property ($rose(sw_mux_to_dac) |-> $past(sw_amp_to_dac))
		else $error("final sample not after transfer");
	a_bus_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("wait state count wrong");
	a_right_view: assert property (rd_done && avs_address[7:5] == 3'h2 |-> avs_readdata[31:10] == 22'h0)
		else $error("right view upper bits set");
	a_left_view: assert property (rd_done && (avs_address[7:5] == 3'h3 || avs_address[7:5] == 3'h4)
		|-> avs_readdata[5:0] == 6'h0 && avs_readdata[31:16] == 16'h0) else $error("left view low bits set");
	a_unmapped_zero: assert property (rd_done && avs_address[7:4] == 4'h2 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
endmodule

bind adcseq_top adcseq_chk #(.ADC_DIV(ADC_DIV)) i_adcseq_chk (.clk(clk), .srst(srst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .mux_sel(mux_sel), .sw_in_to_cap(sw_in_to_cap),
	.sw_amp_to_dac(sw_amp_to_dac), .sw_mux_to_dac(sw_mux_to_dac), .dac_code(dac_code));

// *** test/tb_adcseq_top.sv ***
// self-checking bench for the adc sequencer
`timescale 1ns/1ps
module tb_adcseq_top;
	localparam DIV = 4;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, cmp_in, sw_in_to_cap, sw_amp_to_dac, sw_mux_to_dac;
	wire [3:0] mux_sel;
	wire [9:0] dac_code;
	logic [159:0] levels = '0;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	int n_fs = 0;
	int idx = 0;
	logic mon_on = 1'b0;
	logic p_in = 1'b0;
	logic [1:0] sts;
	logic ten, eight, multi, cont;
	logic [3:0] code;
	logic [31:0] rd;

	adcseq_top #(.ADC_DIV(DIV), .NRES(8)) i_adcseq_top (.clk(clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmp_in(cmp_in), .mux_sel(mux_sel),
		.sw_in_to_cap(sw_in_to_cap), .sw_amp_to_dac(sw_amp_to_dac), .sw_mux_to_dac(sw_mux_to_dac),
		.dac_code(dac_code));
	adcseq_analog i_adcseq_analog (.levels(levels), .mux_sel(mux_sel), .dac_code(dac_code), .cmp_in(cmp_in));

	initial forever #20 clk = ~clk;

	// ----
	// tasks and expectations
	// ----
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// request held until the rising edge that sees waitrequest low; data taken there
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task run_seq(input logic m);
		mon_on <= 1'b0;
		bus(1'b1, 8'h00, {29'h0, ten, sts});
		bus(1'b1, 8'h04, {25'h0, cont, multi, eight, code});
		mon_on <= m;
		rd = 32'h0;
		while (!rd[8])
			bus(1'b0, 8'h08, 32'h0);
	endtask

	task finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	function logic [3:0] exp_mux(input int i);
		if (!multi)
			return code;
		if (!eight)
			return {code[3:2], i[1:0]};
		return {code[3], i[2:0]};
	endfunction

	function logic [31:0] exp_view(input int vw, input logic [9:0] v);
		logic [15:0] left;
		left = ten ? {v, 6'h00} : {v[9:2], 8'h00};
		if (vw == 0)
			return ten ? {22'h0, v} : {24'h0, v[9:2]};
		return vw == 1 ? {16'h0, left ^ 16'h8000} : {16'h0, left};
	endfunction

	// ----
	// phase monitor and timeout
	// ----
	always @(negedge clk) begin
		// an aborted phase is cut short, so nothing is counted while the monitor is off
		if (!mon_on) begin
			n_fs = 0;
			idx = 0;
		end else if (sw_mux_to_dac)
			n_fs++;
		else if (n_fs > 0) begin
			chk("final sample length", DIV * (2 << sts), n_fs);
			n_fs = 0;
		end
		if (mon_on && sw_in_to_cap && !p_in) begin
			chk("input select", exp_mux(idx % (eight ? 8 : 4)), mux_sel);
			idx++;
		end
		p_in = sw_in_to_cap;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			n_fail++;
			finish_test;
		end
	end

	initial begin
		void'($urandom(96));
		repeat (12) @(posedge clk);
		chk("idle outputs", 32'h0, {15'h0, mux_sel, sw_in_to_cap, sw_amp_to_dac, sw_mux_to_dac, dac_code});
		srst <= 1'b0;
		bus(1'b0, 8'h04, 32'h0);
		chk("control reset", 32'h0, rd);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped read", 32'h0, rd);
		for (int t = 0; t < 17; t++) begin
			sts = t[1:0];
			multi = t[2];
			eight = t[3];
			cont = t[4];
			ten = 1'($urandom);
			code = 4'(t * 7);
			// first two tests pin every input to the bottom and the top of the range
			levels <= (t < 2) ? {160{t[0]}} : {$urandom, $urandom, $urandom, $urandom, $urandom};
			run_seq(1'b1);
			chk("status", {22'h0, cont, 1'b1, eight ? 8'hff : 8'h0f}, rd & 32'h3ff);
			for (int n = 0; n < (eight ? 8 : 4); n++)
				if (exp_mux(n) < 4'h8)
					for (int vw = 0; vw < 3; vw++) begin
						bus(1'b0, 8'(8'h40 + 32 * vw + 4 * n), 32'h0);
						chk("result", exp_view(vw, levels[exp_mux(n)*10 +: 10]), rd);
					end
			if (cont) begin
				cont = 1'b0;
				run_seq(1'b0);
			end
			$display("test %0d done", t);
		end
		finish_test;
	end
endmodule
